// File: verilog/bcc_host.sv
// Host end: user registers, bank loader, command issue, result fetch.
// Assumes software uses the one-cycle strobe port below.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module bcc_host (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  cpu_addr,
    input  wire logic [31:0] cpu_wdata,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    output logic      [31:0] cpu_rdata,
    output logic             irq,
    bcc_link_if.host         link
);
    typedef enum logic [2:0] {
        H_IDLE, H_PWR, H_LOAD, H_CMD, H_WAIT, H_FETCH
    } bcc_hst_t;

    bcc_hst_t    st_q;
    logic [31:0] key_q [4];
    logic [31:0] dat_q [4];
    logic [31:0] res_q [4];
    logic        pwr_q;
    logic        pwr_dirty_q;
    logic        go_q;
    logic [1:0]  op_q;
    logic        done_st_q;
    logic        done_mask_q;
    logic [5:0]  cnt_q;
    logic        fetch_v_q;
    logic [3:0]  fetch_i_q;
    logic [7:0]  addr_q;
    logic [7:0]  wdata_q;
    logic        wr_q;
    logic        rd_q;
    logic [31:0] rdata_q;
    logic        irq_q;

    // ==========================================================
    // User port decode
    wire [1:0] wi      = cpu_addr[3:2];
    wire       u_ctrl  = cpu_wr && cpu_addr == bcc_pkg::U_CTRL;
    wire       u_go    = u_ctrl && cpu_wdata[bcc_pkg::CTRL_GO_BIT];
    wire       busy    = (st_q != H_IDLE) || go_q;
    wire       w_key   = cpu_wr && !busy
                         && cpu_addr[7:4] == bcc_pkg::U_KEY[7:4];
    wire       w_dat   = cpu_wr && !busy
                         && cpu_addr[7:4] == bcc_pkg::U_DATA[7:4];
    wire       clr_d   = cpu_wr && cpu_addr == bcc_pkg::U_IRQ_STAT
                         && cpu_wdata[0];
    wire [7:0] ld_byte = cnt_q[4] ? dat_q[cnt_q[3:2]][8*cnt_q[1:0] +: 8]
                                  : key_q[cnt_q[3:2]][8*cnt_q[1:0] +: 8];
    wire [31:0] rd_mux =
        (cpu_addr == bcc_pkg::U_CTRL)     ? {28'h0, op_q, 1'b0, pwr_q}
      : (cpu_addr == bcc_pkg::U_STATUS)   ? {31'h0, busy}
      : (cpu_addr == bcc_pkg::U_IRQ_STAT) ? {31'h0, done_st_q}
      : (cpu_addr == bcc_pkg::U_IRQ_MASK) ? {31'h0, done_mask_q}
      : (cpu_addr[7:4] == bcc_pkg::U_KEY[7:4])    ? key_q[wi]
      : (cpu_addr[7:4] == bcc_pkg::U_DATA[7:4])   ? dat_q[wi]
      : (cpu_addr[7:4] == bcc_pkg::U_RESULT[7:4]) ? res_q[wi]
      : 32'h0;
    wire       fin     = (st_q == H_FETCH) && fetch_v_q
                         && fetch_i_q == 4'hF;

    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_words
            always_ff @(posedge sys_clk)
            begin
                if (!rst_b)
                begin
                    key_q[i] <= 32'h0;
                    dat_q[i] <= 32'h0;
                    res_q[i] <= 32'h0;
                end
                else
                begin
                    if (w_key && wi == 2'(i))
                        key_q[i] <= cpu_wdata;
                    if (w_dat && wi == 2'(i))
                        dat_q[i] <= cpu_wdata;
                    if (fetch_v_q && fetch_i_q[3:2] == 2'(i))
                        res_q[i][8*fetch_i_q[1:0] +: 8] <= link.rdata;
                end
            end
        end
    endgenerate

    // ==========================================================
    // User registers and interrupt
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            pwr_q       <= 1'b0;
            pwr_dirty_q <= 1'b0;
            go_q        <= 1'b0;
            op_q        <= 2'h0;
            done_st_q   <= 1'b0;
            done_mask_q <= 1'b0;
            rdata_q     <= 32'h0;
            irq_q       <= 1'b0;
        end
        else
        begin
            if (u_ctrl && !busy)
            begin
                pwr_q       <= cpu_wdata[bcc_pkg::CTRL_PWR_BIT];
                pwr_dirty_q <= 1'b1;
                op_q        <= cpu_wdata[bcc_pkg::CTRL_OP_LSB +: 2];
                go_q        <= u_go;
            end
            else if (st_q == H_PWR)
            begin
                pwr_dirty_q <= 1'b0;
                go_q        <= 1'b0;
            end
            if (cpu_wr && cpu_addr == bcc_pkg::U_IRQ_MASK)
                done_mask_q <= cpu_wdata[0];
            // Set wins over a clear in the same cycle
            done_st_q <= fin | (done_st_q & ~clr_d);
            irq_q     <= (fin | (done_st_q & ~clr_d)) & done_mask_q;
            rdata_q   <= cpu_rd ? rd_mux : 32'h0;
        end
    end

    // ==========================================================
    // Link sequencer
    always_ff @(posedge sys_clk)
    begin
        wr_q      <= 1'b0;
        rd_q      <= 1'b0;
        fetch_v_q <= 1'b0;
        if (!rst_b)
        begin
            st_q      <= H_IDLE;
            cnt_q     <= 6'h0;
            fetch_i_q <= 4'h0;
            addr_q    <= 8'h00;
            wdata_q   <= 8'h00;
        end
        else
        begin
            unique case (st_q)
                H_IDLE:
                    if (pwr_dirty_q && !u_ctrl)
                        st_q <= H_PWR;
                H_PWR:
                begin
                    // Power bit goes out before any command
                    wr_q    <= 1'b1;
                    addr_q  <= bcc_pkg::ANA_CFG;
                    wdata_q <= {7'h0, pwr_q};
                    cnt_q   <= 6'h0;
                    st_q    <= (go_q && pwr_q) ? H_LOAD : H_IDLE;
                end
                H_LOAD:
                begin
                    // Key bank bytes then data bank bytes
                    wr_q    <= 1'b1;
                    addr_q  <= cnt_q[4] ? bcc_pkg::DATA_BASE + 8'(cnt_q[3:0])
                                        : bcc_pkg::KEY_BASE + 8'(cnt_q[3:0]);
                    wdata_q <= ld_byte;
                    cnt_q   <= cnt_q + 6'h1;
                    if (cnt_q == 6'h1F)
                        st_q <= H_CMD;
                end
                H_CMD:
                begin
                    wr_q    <= 1'b1;
                    addr_q  <= bcc_pkg::CMD_REG;
                    wdata_q <= bcc_pkg::CMD_ENC + 8'(op_q);
                    cnt_q   <= 6'h0;
                    st_q    <= H_WAIT;
                end
                H_WAIT:
                    if (link.eop)
                        st_q <= H_FETCH;
                H_FETCH:
                begin
                    if (!cnt_q[4])
                    begin
                        rd_q   <= 1'b1;
                        addr_q <= bcc_pkg::OUT_BASE + 8'(cnt_q[3:0]);
                        cnt_q  <= cnt_q + 6'h1;
                    end
                    fetch_v_q <= rd_q;
                    fetch_i_q <= addr_q[3:0];
                    if (fin)
                        st_q <= H_IDLE;
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign link.addr  = addr_q;
    assign link.wdata = wdata_q;
    assign link.wr    = wr_q;
    assign link.rd    = rd_q;
    assign cpu_rdata  = rdata_q;
    assign irq        = irq_q;
endmodule : bcc_host

// File: verilog/bcc_pkg.sv
// Constants shared by the cipher co-processor, its engine and its host.
// Assumes one 50 MHz clock and a byte-wide register link between the ends.
package bcc_pkg;

    // ==========================================================
    // Link register map (byte addresses)
    localparam logic [7:0] KEY_BASE   = 8'h00;
    localparam logic [7:0] DATA_BASE  = 8'h10;
    localparam logic [7:0] OUT_BASE   = 8'h20;
    localparam logic [7:0] ANA_CFG    = 8'h30;
    localparam logic [7:0] CMD_REG    = 8'h31;
    localparam logic [7:0] STAT_REG   = 8'h32;
    localparam int         ENGINE_ON_BIT = 0;
    localparam logic [7:0] ANA_RESET  = 8'h00;

    // ==========================================================
    // Command codes written to the command register
    localparam logic [7:0] CMD_ENC    = 8'h01;
    localparam logic [7:0] CMD_KEY    = 8'h02;
    localparam logic [7:0] CMD_DEC    = 8'h03;
    localparam logic [7:0] CMD_KEYDEC = 8'h04;

    typedef enum logic [1:0] {
        OP_ENC, OP_KEY, OP_DEC, OP_KEYDEC
    } bcc_op_t;

    // ==========================================================
    // Host user register map (byte addresses of 32-bit words)
    localparam logic [7:0] U_CTRL     = 8'h00;
    localparam logic [7:0] U_STATUS   = 8'h04;
    localparam logic [7:0] U_IRQ_STAT = 8'h08;
    localparam logic [7:0] U_IRQ_MASK = 8'h0C;
    localparam logic [7:0] U_KEY      = 8'h10;
    localparam logic [7:0] U_DATA     = 8'h20;
    localparam logic [7:0] U_RESULT   = 8'h30;
    localparam int         CTRL_PWR_BIT = 0;
    localparam int         CTRL_GO_BIT  = 1;
    localparam int         CTRL_OP_LSB  = 2;

    // ==========================================================
    // Engine timing
    localparam int         ROUNDS     = 10;

endpackage : bcc_pkg

// File: verilog/bcc_link_if.sv
// Byte-wide register link between host and co-processor.
// Assumes both ends share sys_clk; read data follow a read by one cycle.
`timescale 1ns/1ps
interface bcc_link_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       eop;

    modport dev  (input addr, input wdata, input wr, input rd,
                  output rdata, output eop);
    modport host (output addr, output wdata, output wr, output rd,
                  input rdata, input eop);
endinterface : bcc_link_if

// File: verilog/bcc_engine.sv
// Iterative 128-bit block engine with forward and inverse key schedule.
// Assumes start is a pulse given only while busy is low.
`timescale 1ns/1ps
module bcc_engine #(
    parameter int NR = bcc_pkg::ROUNDS
) (
    input  wire logic            sys_clk,
    input  wire logic            rst_b,
    input  wire logic            start,
    input  wire bcc_pkg::bcc_op_t op,
    input  wire logic [127:0]    key,
    input  wire logic [127:0]    data,
    output logic                 busy,
    output logic                 done,
    output logic [127:0]         result
);
    typedef enum logic [1:0] {E_IDLE, E_FWD, E_INV} bcc_est_t;

    bcc_est_t         st_q;
    bcc_pkg::bcc_op_t op_q;
    logic [127:0]     s_q;
    logic [127:0]     k_q;
    logic [3:0]       cnt_q;

    // ==========================================================
    // Round datapath
    wire  [127:0] rc      = {124'h0, cnt_q};
    wire  [127:0] k_next  = {k_q[126:0], k_q[127]} ^ rc;
    wire  [127:0] sx      = s_q ^ k_q;
    wire  [127:0] s_enc   = {sx[122:0], sx[127:123]};
    wire  [127:0] kx      = k_q ^ rc;
    wire  [127:0] k_prev  = {kx[0], kx[127:1]};
    wire  [127:0] s_dec   = {s_q[4:0], s_q[127:5]} ^ k_prev;
    wire          last_f  = (cnt_q == 4'(NR - 1));
    wire          last_i  = (cnt_q == 4'h0);

    assign busy = (st_q != E_IDLE);

    always_ff @(posedge sys_clk)
    begin
        done <= 1'b0;
        if (!rst_b)
        begin
            st_q   <= E_IDLE;
            op_q   <= bcc_pkg::OP_ENC;
            s_q    <= 128'h0;
            k_q    <= 128'h0;
            cnt_q  <= 4'h0;
            result <= 128'h0;
        end
        else
        begin
            unique case (st_q)
                E_IDLE:
                    if (start)
                    begin
                        op_q <= op;
                        if (op == bcc_pkg::OP_DEC)
                        begin
                            s_q   <= data ^ key;
                            k_q   <= key;
                            cnt_q <= 4'(NR - 1);
                            st_q  <= E_INV;
                        end
                        else
                        begin
                            // Derivation takes its key from the data bank
                            k_q   <= (op == bcc_pkg::OP_KEY) ? data
                                                             : key;
                            s_q   <= data;
                            cnt_q <= 4'h0;
                            st_q  <= E_FWD;
                        end
                    end
                E_FWD:
                begin
                    s_q   <= s_enc;
                    k_q   <= k_next;
                    cnt_q <= cnt_q + 4'h1;
                    if (last_f)
                    begin
                        if (op_q == bcc_pkg::OP_KEYDEC)
                        begin
                            s_q   <= data ^ k_next;
                            cnt_q <= 4'(NR - 1);
                            st_q  <= E_INV;
                        end
                        else
                        begin
                            result <= (op_q == bcc_pkg::OP_KEY) ? k_next
                                      : s_enc ^ k_next;
                            done   <= 1'b1;
                            st_q   <= E_IDLE;
                        end
                    end
                end
                E_INV:
                begin
                    s_q   <= s_dec;
                    k_q   <= k_prev;
                    cnt_q <= cnt_q - 4'h1;
                    if (last_i)
                    begin
                        result <= s_dec;
                        done   <= 1'b1;
                        st_q   <= E_IDLE;
                    end
                end
                default: st_q <= E_IDLE;
            endcase
        end
    end
endmodule : bcc_engine

// File: verilog/bcc_dev.sv
// Co-processor end: key, data and result banks, power bit, command decode.
// Assumes the host drives the link by the one-cycle strobe protocol.
`timescale 1ns/1ps
module bcc_dev (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    bcc_link_if.dev   link
);
    logic [7:0]   key_q  [16];
    logic [7:0]   data_q [16];
    logic [7:0]   ana_q;
    logic [7:0]   rdata_q;
    logic         eop_q;
    logic         start_q;
    bcc_pkg::bcc_op_t op_q;
    logic [127:0] key_w;
    logic [127:0] data_w;
    logic [127:0] res_w;
    logic         busy_w;
    logic         done_w;

    // ==========================================================
    // Decode; no mode input exists, so banks answer in every mode
    wire [3:0] idx     = link.addr[3:0];
    wire       sel_key = (link.addr[7:4] == bcc_pkg::KEY_BASE[7:4]);
    wire       sel_dat = (link.addr[7:4] == bcc_pkg::DATA_BASE[7:4]);
    wire       sel_out = (link.addr[7:4] == bcc_pkg::OUT_BASE[7:4]);
    wire       eng_on  = ana_q[bcc_pkg::ENGINE_ON_BIT];
    wire       cmd_wr  = link.wr && (link.addr == bcc_pkg::CMD_REG);
    wire       cmd_ok  = (link.wdata >= bcc_pkg::CMD_ENC)
                         && (link.wdata <= bcc_pkg::CMD_KEYDEC);
    // Off or busy engine drops the command
    wire       take    = cmd_wr && cmd_ok && eng_on && !busy_w
                         && !start_q;
    wire [1:0] op_code = 2'(link.wdata - bcc_pkg::CMD_ENC);
    wire [7:0] res_b   = res_w[8*idx +: 8];
    wire [7:0] rd_mux  = sel_key ? key_q[idx]
                       : sel_dat ? data_q[idx]
                       : sel_out ? res_b
                       : (link.addr == bcc_pkg::ANA_CFG) ? ana_q
                       : (link.addr == bcc_pkg::STAT_REG)
                         ? {7'h0, busy_w | start_q}
                       : 8'h00;

    generate
        for (genvar i = 0; i < 16; i++)
        begin : g_pack
            assign key_w[8*i +: 8]  = key_q[i];
            assign data_w[8*i +: 8] = data_q[i];
            always_ff @(posedge sys_clk)
            begin
                if (!rst_b)
                begin
                    key_q[i]  <= 8'h00;
                    data_q[i] <= 8'h00;
                end
                else if (link.wr && idx == 4'(i))
                begin
                    if (sel_key)
                        key_q[i] <= link.wdata;
                    if (sel_dat)
                        data_q[i] <= link.wdata;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Control and read path
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            ana_q   <= bcc_pkg::ANA_RESET;
            rdata_q <= 8'h00;
            eop_q   <= 1'b0;
            start_q <= 1'b0;
            op_q    <= bcc_pkg::OP_ENC;
        end
        else
        begin
            if (link.wr && link.addr == bcc_pkg::ANA_CFG)
                ana_q <= link.wdata;
            rdata_q <= link.rd ? rd_mux : 8'h00;
            start_q <= take;
            if (take)
                op_q <= bcc_pkg::bcc_op_t'(op_code);
            eop_q   <= done_w;
        end
    end

    assign link.rdata = rdata_q;
    assign link.eop   = eop_q;

    bcc_engine #(
        .NR     (bcc_pkg::ROUNDS)
    ) u_engine (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .start   (start_q),
        .op      (op_q),
        .key     (key_w),
        .data    (data_w),
        .busy    (busy_w),
        .done    (done_w),
        .result  (res_w)
    );
endmodule : bcc_dev

// File: bench/bcc_link_properties.sv
// Concurrent checks on the host to co-processor register link.
// Assumes plain link signals on sys_clk, with rst_b low as reset.
`timescale 1ns/1ps
module bcc_link_properties (
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       eop
);
    // ==========================================================
    // Shadow of the power bit and of the engine countdown
    localparam int ENC_LAT = bcc_pkg::ROUNDS + 3;
    localparam int KD_LAT  = 2 * bcc_pkg::ROUNDS + 3;
    logic       pwr_q;
    logic       pwr_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    wire        cmd_wr  = wr && addr == bcc_pkg::CMD_REG;
    wire        is_kd   = wdata == bcc_pkg::CMD_KEYDEC;
    wire        code_ok = wdata >= bcc_pkg::CMD_ENC
                          && wdata <= bcc_pkg::CMD_KEYDEC;
    wire        accept  = cmd_wr && pwr_q && cnt_q == 5'h00 && code_ok;
    wire        cfg_wr  = wr && addr == bcc_pkg::ANA_CFG;
    assign pwr_d = cfg_wr ? wdata[bcc_pkg::ENGINE_ON_BIT] : pwr_q;
    assign cnt_d = !accept ? cnt_q - {4'h0, cnt_q != 5'h00}
                 : is_kd ? 5'(KD_LAT) : 5'(ENC_LAT);
    always_ff @(posedge sys_clk)
    begin
        pwr_q <= rst_b ? pwr_d : 1'b0;
        cnt_q <= rst_b ? cnt_d : 5'h00;
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_one_strobe; !(wr && rd); endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("write and read strobes together");
    property p_rdata_idle; !$past(rd) |-> rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside the answer cycle");
    property p_eop_pulse; eop |=> !eop; endproperty
    a_eop_pulse: assert property (p_eop_pulse)
        else $error("done event longer than one cycle");
    property p_eop_short; accept && !is_kd |-> ##13 eop; endproperty
    a_eop_short: assert property (p_eop_short)
        else $error("done event late for single pass");
    property p_eop_long; accept && is_kd |-> ##23 eop; endproperty
    a_eop_long: assert property (p_eop_long)
        else $error("done event late for derive then decrypt");
    property p_eop_cause; eop |-> cnt_q == 5'h01; endproperty
    a_eop_cause: assert property (p_eop_cause)
        else $error("done event without accepted command");
    property p_cmd_pwr; cmd_wr |-> pwr_q; endproperty
    a_cmd_pwr: assert property (p_cmd_pwr)
        else $error("command sent with engine off");
    property p_read_idle;
        rd && addr[7:4] == 4'h2 |-> cnt_q == 5'h00;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("result read before done event");
endmodule : bcc_link_properties

// File: bench/tb.sv
// Top testbench: host and co-processor joined by the link interface.
// Assumes the user port strobe protocol and a 50 MHz sys_clk.
`timescale 1ns/1ps
module tb;
    typedef struct {
        bcc_pkg::bcc_op_t op;
        int               ki;
        int               di;
        int               si;
        int               ei;
    } bcc_row_t;
    logic         sys_clk;
    logic         rst_b;
    logic [7:0]   cpu_addr;
    logic [31:0]  cpu_wdata;
    logic         cpu_wr;
    logic         cpu_rd;
    logic [31:0]  cpu_rdata;
    logic         irq;
    logic [127:0] pool [8];
    logic [127:0] r;
    int           fail_count;
    int           checks_done;
    int           cycles;
    bcc_row_t     rows [9];

    bcc_link_if link ();
    bcc_dev bcc_dev_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(link.dev));
    bcc_host bcc_host_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .irq(irq),
        .link(link.host));
    bcc_link_properties bcc_link_properties_i (.sys_clk(sys_clk),
        .rst_b(rst_b), .addr(link.addr), .wdata(link.wdata), .wr(link.wr),
        .rd(link.rd), .rdata(link.rdata), .eop(link.eop));

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Hang guard: whole run needs well under 20000 cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    // ==========================================================
    // Tasks
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Strobe pulses end with a spare edge so calls never collide
    task automatic wr_word(input logic [7:0] a, input logic [31:0] d);
        cpu_addr  <= a;
        cpu_wdata <= d;
        cpu_wr    <= 1'b1;
        @(posedge sys_clk);
        cpu_wr    <= 1'b0;
        @(posedge sys_clk);
    endtask : wr_word

    task automatic rd_word(input logic [7:0] a, output logic [31:0] d);
        cpu_addr <= a;
        cpu_rd   <= 1'b1;
        @(posedge sys_clk);
        cpu_rd   <= 1'b0;
        #1 d = cpu_rdata;
        @(posedge sys_clk);
    endtask : rd_word

    task automatic start(input bcc_pkg::bcc_op_t op,
                         input logic [127:0] k, input logic [127:0] d);
        for (int w = 0; w < 4; w++)
            wr_word(bcc_pkg::U_KEY + 8'(4 * w), k[32 * w +: 32]);
        for (int w = 0; w < 4; w++)
            wr_word(bcc_pkg::U_DATA + 8'(4 * w), d[32 * w +: 32]);
        wr_word(bcc_pkg::U_CTRL, {28'h0000000, op, 2'b11});
    endtask : start

    task automatic finish_op(output logic [127:0] res);
        logic [31:0] v;
        v = 32'h00000000;
        for (int n = 0; n < 100 && !v[0]; n++)
            rd_word(bcc_pkg::U_IRQ_STAT, v);
        check(v[0], 1'b1);
        for (int w = 0; w < 4; w++)
        begin
            rd_word(bcc_pkg::U_RESULT + 8'(4 * w), v);
            res[32 * w +: 32] = v;
        end
    endtask : finish_op

    task automatic clear_done();
        wr_word(bcc_pkg::U_IRQ_STAT, 32'h00000001);
        check(irq, 1'b0);
    endtask : clear_done

    // ==========================================================
    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        cpu_addr = 8'h00;
        cpu_wdata = 32'h00000000;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        pool = '{128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0,
                 128'h00112233445566778899AABBCCDDEEFF, 128'h0, 128'h0,
                 128'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF,
                 128'h00000000000000000000000000000001, 128'h0, 128'h0};
        rows = '{'{bcc_pkg::OP_ENC, 0, 1, 2, -1},
                 '{bcc_pkg::OP_KEY, 0, 0, 3, -1},
                 '{bcc_pkg::OP_DEC, 3, 2, -1, 1},
                 '{bcc_pkg::OP_KEYDEC, 0, 2, -1, 1},
                 '{bcc_pkg::OP_ENC, 0, 1, -1, 2},
                 '{bcc_pkg::OP_ENC, 4, 5, 6, -1},
                 '{bcc_pkg::OP_KEY, 5, 4, 7, -1},
                 '{bcc_pkg::OP_DEC, 7, 6, -1, 5},
                 '{bcc_pkg::OP_KEYDEC, 4, 6, -1, 5}};
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        check(irq, 1'b0);
        rd_word(bcc_pkg::U_RESULT, r[31:0]);
        check(r[31:0], 32'h00000000);
        wr_word(bcc_pkg::U_IRQ_MASK, 32'h00000001);
        foreach (rows[i])
        begin
            start(rows[i].op, pool[rows[i].ki], pool[rows[i].di]);
            finish_op(r);
            check(irq, 1'b1);
            if (rows[i].si >= 0)
                pool[rows[i].si] = r;
            if (rows[i].ei >= 0)
                check(r, pool[rows[i].ei]);
            clear_done();
        end
        // Round trips alone would pass an engine that copies its input
        check(pool[2] != pool[1], 1'b1);
        check(pool[3] != pool[0], 1'b1);
        // Key and command writes while busy must change nothing
        start(bcc_pkg::OP_ENC, pool[0], pool[1]);
        wr_word(bcc_pkg::U_KEY, 32'hFFFFFFFF);
        wr_word(bcc_pkg::U_CTRL, 32'h0000000B);
        rd_word(bcc_pkg::U_STATUS, r[31:0]);
        check(r[31:0], 32'h00000001);
        rd_word(bcc_pkg::U_CTRL, r[31:0]);
        check(r[31:0], 32'h00000001);
        finish_op(r);
        check(r, pool[2]);
        clear_done();
        // Masked completion keeps irq low until unmasked
        wr_word(bcc_pkg::U_IRQ_MASK, 32'h00000000);
        start(bcc_pkg::OP_DEC, pool[3], pool[2]);
        finish_op(r);
        check(irq, 1'b0);
        check(r, pool[1]);
        wr_word(bcc_pkg::U_IRQ_MASK, 32'h00000001);
        // Irq follows the mask one cycle late
        @(posedge sys_clk);
        check(irq, 1'b1);
        clear_done();
        // Go with the power bit clear sends no command
        wr_word(bcc_pkg::U_CTRL, 32'h00000002);
        repeat (60) @(posedge sys_clk);
        rd_word(bcc_pkg::U_IRQ_STAT, r[31:0]);
        check(r[31:0], 32'h00000000);
        rd_word(bcc_pkg::U_STATUS, r[31:0]);
        check(r[31:0], 32'h00000000);
        // Reset in mid operation clears result and status
        start(bcc_pkg::OP_KEYDEC, pool[0], pool[2]);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd_word(bcc_pkg::U_IRQ_STAT, r[31:0]);
        check(r[31:0], 32'h00000000);
        rd_word(bcc_pkg::U_RESULT, r[31:0]);
        check(r[31:0], 32'h00000000);
        check(irq, 1'b0);
        test_done();
    end
endmodule : tb
